// ===== magc_cfg.svh
// register map, field positions, reset values and timing constants of the gain control block
// What this block does
// - While peak exceeds the active attack threshold, lower gain in half-decibel steps.
// - While peak stays below release threshold, raise gain toward initial in half-decibel steps.
// - Below the third attack threshold only battery protection can attack, once peak exceeds its battery peak limit.
// - Clipping above first threshold runs the fastest level, rate from level1 bits 2:1.
// - Every gain step, attack or release, is applied only at a zero crossing.
// - Above second threshold without clipping, second level acts, rate from level2 bits 4:2.
// - Between second and third thresholds, the slowest level acts, rate from level3 bits 4:2.
// - After peak first drops below release threshold, gain holds for ten to twenty ms.
// - Release starts only after the hold interval, stepping at rate from level3 bits 7:5.
// - Release stops when peak rises above release threshold or gain is back to initial.
// - Each of the three levels is enabled or disabled independently.
// - Battery below safety threshold makes gain drop rapidly to limit voltage and current.
// - Battery safety threshold 3.5 to 3.6 V chosen by battery config bits 4:3.
// - Peak limit during battery protection 5 to 6.5 Vp chosen by bits 1:0.
// - Battery protection acts only while battery config bit 2 is one.
// - Boost target voltage comes from boost voltage config bits 2:0.
// - Boost input current limit comes from boost current limit bits 2:0.
// - Battery protection clears only after battery rises 100 mV above threshold.
// - Total gain reduction is limited to 13.5 dB below initial gain.
`ifndef MAGC_CFG_SVH
`define MAGC_CFG_SVH

// register offsets
`define MAGC_OFS_STATUS 8'h01
`define MAGC_OFS_BATCFG 8'h02
`define MAGC_OFS_BSTV 8'h03
`define MAGC_OFS_BSTI 8'h04
`define MAGC_OFS_L3CFG 8'h07
`define MAGC_OFS_L2CFG 8'h08
`define MAGC_OFS_L1CFG 8'h09

// reset values
`define MAGC_RST_BATCFG 8'h04
`define MAGC_RST_BSTV 8'h00
`define MAGC_RST_BSTI 8'h00
`define MAGC_RST_L3CFG 8'h01
`define MAGC_RST_L2CFG 8'h01
`define MAGC_RST_L1CFG 8'h01

// field positions
`define MAGC_EN_BIT 0
`define MAGC_BAT_EN_BIT 2
`define MAGC_BAT_TH_MSB 4
`define MAGC_BAT_TH_LSB 3
`define MAGC_BAT_LIM_MSB 1
`define MAGC_BAT_LIM_LSB 0
`define MAGC_L1_RATE_MSB 2
`define MAGC_L1_RATE_LSB 1
`define MAGC_AT_RATE_MSB 4
`define MAGC_AT_RATE_LSB 2
`define MAGC_RLS_RATE_MSB 7
`define MAGC_RLS_RATE_LSB 5
`define MAGC_BST_MSB 2

// gain stepping: 0.5 dB per step, 13.5 dB at most
`define MAGC_MAX_ATTEN 5'h1B

// battery levels in mV
`define MAGC_BAT_TH0 13'h0DAC
`define MAGC_BAT_TH1 13'h0DCD
`define MAGC_BAT_TH2 13'h0DEF
`define MAGC_BAT_TH3 13'h0E10
`define MAGC_BAT_HYS 13'h0064
`define MAGC_LIM0 14'h1388
`define MAGC_LIM1 14'h157C
`define MAGC_LIM2 14'h1770
`define MAGC_LIM3 14'h1964

// timing, times in us, clock in MHz
`define MAGC_CLK_MHZ 25
`define MAGC_L1_BASE_US 20
`define MAGC_L2_BASE_US 80
`define MAGC_L3_BASE_US 320
`define MAGC_RLS_BASE_US 640
`define MAGC_HOLD_US 15000

`endif

// ===== magc_pkg.sv
// types of the gain control block
package magc_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_ATTACK = 2'h1,
        ST_HOLD = 2'h3,
        ST_RELEASE = 2'h2
    } magc_state_e;

    typedef struct packed
    {
        logic q1;
        logic q2;
        logic q3;
        logic bat;
        logic below_rt;
    } magc_cmp_s;

endpackage : magc_pkg

// ===== magc_step_timer.sv
// interval timer giving a one-cycle pulse after each period of cycles while running
`timescale 1ns/1ns
`default_nettype none

module magc_step_timer #(
    parameter int TW = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [TW-1:0] period_i,
    output logic expire_o
);

    logic [TW-1:0] cnt_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            cnt_q <= '0;
            expire_o <= 1'b0;
        end
        else if (cnt_q >= period_i - TW'(1))
        begin
            cnt_q <= '0;
            expire_o <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + TW'(1);
            expire_o <= 1'b0;
        end
    end

endmodule : magc_step_timer

`default_nettype wire

// ===== magc_gain_ctrl.sv
// multi-level gain control with hold, release and battery protection
`timescale 1ns/1ns
`default_nettype none
`include "magc_cfg.svh"

module magc_gain_ctrl #(
    parameter int TW = 24,
    parameter int L1_BASE_CYC = `MAGC_L1_BASE_US * `MAGC_CLK_MHZ,
    parameter int L2_BASE_CYC = `MAGC_L2_BASE_US * `MAGC_CLK_MHZ,
    parameter int L3_BASE_CYC = `MAGC_L3_BASE_US * `MAGC_CLK_MHZ,
    parameter int RLS_BASE_CYC = `MAGC_RLS_BASE_US * `MAGC_CLK_MHZ,
    parameter int HOLD_CYC = `MAGC_HOLD_US * `MAGC_CLK_MHZ,
    parameter logic [13:0] AT1_MV = 14'h1F40,
    parameter logic [13:0] AT2_MV = 14'h1B58,
    parameter logic [13:0] AT3_MV = 14'h1770,
    parameter logic [13:0] RT_MV = 14'h157C
) (
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic REG_WE_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic [13:0] PEAK_MV_I,
    input wire logic CLIP_I,
    input wire logic ZERO_CROSS_I,
    input wire logic [12:0] BAT_MV_I,
    output logic [4:0] ATTEN_O,
    output logic [1:0] AGC_LEVEL_O,
    output logic BAT_PROTECT_O,
    output logic [2:0] BOOST_VSEL_O,
    output logic [2:0] BOOST_ILIM_O
);

    localparam logic [TW-1:0] L1_P = TW'(L1_BASE_CYC);
    localparam logic [TW-1:0] L2_P = TW'(L2_BASE_CYC);
    localparam logic [TW-1:0] L3_P = TW'(L3_BASE_CYC);
    localparam logic [TW-1:0] RLS_P = TW'(RLS_BASE_CYC);
    localparam logic [TW-1:0] HOLD_P = TW'(HOLD_CYC);

    logic [7:0] bat_cfg_q;
    logic [7:0] bst_v_q;
    logic [7:0] bst_i_q;
    logic [7:0] l3_cfg_q;
    logic [7:0] l2_cfg_q;
    logic [7:0] l1_cfg_q;
    logic [7:0] rdata_q;
    logic [4:0] atten_q;
    logic [1:0] level_q;
    logic bat_low_q;
    logic prot_q;
    logic pend_q;
    magc_pkg::magc_state_e state_q;
    magc_pkg::magc_state_e state_d;
    magc_pkg::magc_cmp_s cmp;
    logic att_req;
    logic [1:0] level_sel;
    logic [TW-1:0] rate_p;
    logic [12:0] bat_th;
    logic [13:0] peak_lim;
    logic stepping;
    logic rate_exp;
    logic hold_exp;
    logic step_now;

    ////////////////////////////////////////////////////////////////////////////
    // register file
    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            bat_cfg_q <= `MAGC_RST_BATCFG;
            bst_v_q <= `MAGC_RST_BSTV;
            bst_i_q <= `MAGC_RST_BSTI;
            l3_cfg_q <= `MAGC_RST_L3CFG;
            l2_cfg_q <= `MAGC_RST_L2CFG;
            l1_cfg_q <= `MAGC_RST_L1CFG;
        end
        else if (REG_WE_I)
        begin
            case (REG_ADDR_I)
                `MAGC_OFS_BATCFG: bat_cfg_q <= REG_WDATA_I;
                `MAGC_OFS_BSTV: bst_v_q <= REG_WDATA_I;
                `MAGC_OFS_BSTI: bst_i_q <= REG_WDATA_I;
                `MAGC_OFS_L3CFG: l3_cfg_q <= REG_WDATA_I;
                `MAGC_OFS_L2CFG: l2_cfg_q <= REG_WDATA_I;
                `MAGC_OFS_L1CFG: l1_cfg_q <= REG_WDATA_I;
                default: ;
            endcase
        end
    end

    // read data, unmapped offsets read zero
    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            case (REG_ADDR_I)
                `MAGC_OFS_STATUS: rdata_q <= {prot_q, level_q, atten_q};
                `MAGC_OFS_BATCFG: rdata_q <= bat_cfg_q;
                `MAGC_OFS_BSTV: rdata_q <= bst_v_q;
                `MAGC_OFS_BSTI: rdata_q <= bst_i_q;
                `MAGC_OFS_L3CFG: rdata_q <= l3_cfg_q;
                `MAGC_OFS_L2CFG: rdata_q <= l2_cfg_q;
                `MAGC_OFS_L1CFG: rdata_q <= l1_cfg_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign REG_RDATA_O = rdata_q;
    assign BOOST_VSEL_O = bst_v_q[`MAGC_BST_MSB:0];
    assign BOOST_ILIM_O = bst_i_q[`MAGC_BST_MSB:0];

    ////////////////////////////////////////////////////////////////////////////
    // battery protection
    always_comb
    begin
        case (bat_cfg_q[`MAGC_BAT_TH_MSB:`MAGC_BAT_TH_LSB])
            2'h0: bat_th = `MAGC_BAT_TH0;
            2'h1: bat_th = `MAGC_BAT_TH1;
            2'h2: bat_th = `MAGC_BAT_TH2;
            default: bat_th = `MAGC_BAT_TH3;
        endcase
        case (bat_cfg_q[`MAGC_BAT_LIM_MSB:`MAGC_BAT_LIM_LSB])
            2'h0: peak_lim = `MAGC_LIM0;
            2'h1: peak_lim = `MAGC_LIM1;
            2'h2: peak_lim = `MAGC_LIM2;
            default: peak_lim = `MAGC_LIM3;
        endcase
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            bat_low_q <= 1'b0;
        end
        else if (BAT_MV_I < bat_th)
        begin
            bat_low_q <= 1'b1;
        end
        else if (BAT_MV_I >= bat_th + `MAGC_BAT_HYS)
        begin
            bat_low_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // level qualification and rate selection
    always_comb
    begin
        cmp.q1 = l1_cfg_q[`MAGC_EN_BIT] && CLIP_I && (PEAK_MV_I > AT1_MV);
        cmp.q2 = l2_cfg_q[`MAGC_EN_BIT] && (PEAK_MV_I > AT2_MV);
        cmp.q3 = l3_cfg_q[`MAGC_EN_BIT] && (PEAK_MV_I > AT3_MV);
        cmp.bat = bat_cfg_q[`MAGC_BAT_EN_BIT] && bat_low_q && (PEAK_MV_I > peak_lim);
        cmp.below_rt = PEAK_MV_I < RT_MV;
        att_req = cmp.q1 || cmp.q2 || cmp.q3 || cmp.bat;
        if (cmp.q1 || cmp.bat)
        begin
            level_sel = 2'h1;
        end
        else if (cmp.q2)
        begin
            level_sel = 2'h2;
        end
        else if (cmp.q3)
        begin
            level_sel = 2'h3;
        end
        else
        begin
            level_sel = 2'h0;
        end
        case (level_sel)
            2'h1: rate_p = L1_P << l1_cfg_q[`MAGC_L1_RATE_MSB:`MAGC_L1_RATE_LSB];
            2'h2: rate_p = L2_P << l2_cfg_q[`MAGC_AT_RATE_MSB:`MAGC_AT_RATE_LSB];
            2'h3: rate_p = L3_P << l3_cfg_q[`MAGC_AT_RATE_MSB:`MAGC_AT_RATE_LSB];
            default: rate_p = RLS_P << l3_cfg_q[`MAGC_RLS_RATE_MSB:`MAGC_RLS_RATE_LSB];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // attack, hold and release sequencing
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            magc_pkg::ST_IDLE:
            begin
                if (att_req)
                    state_d = magc_pkg::ST_ATTACK;
                else if (cmp.below_rt && atten_q != 5'h00)
                    state_d = magc_pkg::ST_HOLD;
            end
            magc_pkg::ST_ATTACK:
            begin
                if (!att_req)
                    state_d = cmp.below_rt ? magc_pkg::ST_HOLD : magc_pkg::ST_IDLE;
            end
            magc_pkg::ST_HOLD:
            begin
                if (att_req)
                    state_d = magc_pkg::ST_ATTACK;
                else if (!cmp.below_rt)
                    state_d = magc_pkg::ST_IDLE;
                else if (hold_exp)
                    state_d = magc_pkg::ST_RELEASE;
            end
            magc_pkg::ST_RELEASE:
            begin
                if (att_req)
                    state_d = magc_pkg::ST_ATTACK;
                else if (!cmp.below_rt || atten_q == 5'h00)
                    state_d = magc_pkg::ST_IDLE;
            end
            default: state_d = magc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I)
            state_q <= magc_pkg::ST_IDLE;
        else
            state_q <= state_d;
    end

    assign stepping = (state_q == magc_pkg::ST_ATTACK) || (state_q == magc_pkg::ST_RELEASE);

    magc_step_timer #(
        .TW(TW)
    ) u_rate_timer (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .run_i(stepping),
        .period_i(rate_p),
        .expire_o(rate_exp)
    );

    magc_step_timer #(
        .TW(TW)
    ) u_hold_timer (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .run_i(state_q == magc_pkg::ST_HOLD),
        .period_i(HOLD_P),
        .expire_o(hold_exp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pending step, applied at the next zero crossing
    assign step_now = pend_q && ZERO_CROSS_I && stepping;

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I || !stepping)
            pend_q <= 1'b0;
        else if (rate_exp)
            pend_q <= 1'b1;
        else if (ZERO_CROSS_I)
            pend_q <= 1'b0;
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            atten_q <= 5'h00;
        end
        else if (step_now && state_q == magc_pkg::ST_ATTACK && att_req && atten_q < `MAGC_MAX_ATTEN)
        begin
            atten_q <= atten_q + 5'h01;
        end
        else if (step_now && state_q == magc_pkg::ST_RELEASE && !att_req && cmp.below_rt && atten_q != 5'h00)
        begin
            atten_q <= atten_q - 5'h01;
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            level_q <= 2'h0;
            prot_q <= 1'b0;
        end
        else
        begin
            level_q <= level_sel;
            prot_q <= bat_cfg_q[`MAGC_BAT_EN_BIT] && bat_low_q;
        end
    end

    assign ATTEN_O = atten_q;
    assign AGC_LEVEL_O = level_q;
    assign BAT_PROTECT_O = prot_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    chk_step_zero_cross: assert property (atten_q != $past(atten_q) |-> $past(ZERO_CROSS_I) && $past(pend_q))
        else $error("gain moved outside a zero crossing");
    chk_attack_step: assert property (state_q == magc_pkg::ST_ATTACK && step_now
        && att_req && atten_q < `MAGC_MAX_ATTEN |=> atten_q == $past(atten_q) + 5'h01)
        else $error("attack step missing");
    chk_release_step: assert property (state_q == magc_pkg::ST_RELEASE && step_now && atten_q != 5'h00
        && !att_req && cmp.below_rt |=> atten_q == $past(atten_q) - 5'h01)
        else $error("release step missing");
    chk_no_idle_attack: assert property (atten_q > $past(atten_q) |-> $past(att_req))
        else $error("gain reduced without a qualifying level");
    chk_atten_limit: assert property (atten_q <= `MAGC_MAX_ATTEN)
        else $error("attenuation beyond limit");
    chk_release_after_hold: assert property ($rose(state_q == magc_pkg::ST_RELEASE) |-> $past(hold_exp))
        else $error("release began before hold elapsed");
    chk_hold_no_step: assert property (state_q == magc_pkg::ST_HOLD ##1 state_q == magc_pkg::ST_HOLD
        |-> atten_q == $past(atten_q))
        else $error("gain changed during hold");
    chk_release_stop: assert property (state_q == magc_pkg::ST_RELEASE && !att_req && !cmp.below_rt
        |=> state_q == magc_pkg::ST_IDLE)
        else $error("release did not stop");
    chk_level_priority: assert property (cmp.q1 |=> level_q == 2'h1)
        else $error("fastest level not selected");
    chk_bat_gate: assert property (!bat_cfg_q[`MAGC_BAT_EN_BIT] |=> !prot_q)
        else $error("battery protection active while disabled");
    chk_bat_hyst: assert property (bat_low_q && BAT_MV_I >= bat_th && BAT_MV_I < bat_th + `MAGC_BAT_HYS
        |=> bat_low_q)
        else $error("battery protection cleared inside hysteresis");
    chk_boost_field: assert property (REG_WE_I && REG_ADDR_I == `MAGC_OFS_BSTV
        |=> BOOST_VSEL_O == $past(REG_WDATA_I[`MAGC_BST_MSB:0]))
        else $error("boost voltage field not taken from write");
    chk_boost_ilim: assert property (REG_WE_I && REG_ADDR_I == `MAGC_OFS_BSTI
        |=> BOOST_ILIM_O == $past(REG_WDATA_I[`MAGC_BST_MSB:0]))
        else $error("boost current field not taken from write");

    cov_attack: cover property (state_q == magc_pkg::ST_ATTACK && step_now);
    cov_release: cover property (state_q == magc_pkg::ST_RELEASE && step_now);
    cov_battery: cover property (cmp.bat && step_now);

endmodule : magc_gain_ctrl

`default_nettype wire

// ===== magc_host_model.sv
// host model driving the register port of the gain control block
`timescale 1ns/1ns
`default_nettype none

module magc_host_model (
    input wire logic clk_i,
    output logic we_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i
);
    initial
    begin
        we_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    // one write strobe, then the data lines stop showing the written value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        we_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(posedge clk_i);
        #1;
        we_o = 1'b0;
        wdata_o = ~d;
    endtask : wr

    // read data is registered one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        @(posedge clk_i);
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask : rd
endmodule : magc_host_model

`default_nettype wire

// ===== magc_gain_ctrl_tb.sv
// self-checking testbench of the gain control block
`timescale 1ns/1ns
`default_nettype none
`include "magc_cfg.svh"

module magc_gain_ctrl_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [13:0] peak = 14'h0000;
    logic clip = 1'b0;
    logic zc = 1'b0;
    logic [12:0] bat = 13'h1000;
    logic [4:0] atten;
    logic [1:0] lvl;
    logic prot;
    logic [2:0] vsel;
    logic [2:0] ilim;
    int failures = 0;
    int checks = 0;
    int cyc = 0;

    always #20 clk = ~clk;

    magc_host_model host (.clk_i(clk), .we_o(we), .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));

    magc_gain_ctrl #(.L1_BASE_CYC(4), .L2_BASE_CYC(8), .L3_BASE_CYC(16), .RLS_BASE_CYC(16), .HOLD_CYC(40)) dut (
        .CORE_CLK_I(clk), .SYS_RST_I(rst), .REG_WE_I(we), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_RDATA_O(rdata), .PEAK_MV_I(peak), .CLIP_I(clip), .ZERO_CROSS_I(zc), .BAT_MV_I(bat),
        .ATTEN_O(atten), .AGC_LEVEL_O(lvl), .BAT_PROTECT_O(prot), .BOOST_VSEL_O(vsel), .BOOST_ILIM_O(ilim)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            failures++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles

    task automatic do_reset(input int n);
        @(posedge clk);
        #1;
        rst = 1'b1;
        peak = 14'h0000;
        clip = 1'b0;
        bat = 13'h1000;
        cycles(n);
        rst = 1'b0;
    endtask : do_reset

    // zero-cross pulses every second cycle until the attenuation reaches the target or n pulses have been given
    task automatic zc_until(input logic [4:0] exp, input int n);
        for (int i = 0; i < n && atten !== exp; i++)
        begin
            zc = 1'b1;
            cycles(1);
            zc = 1'b0;
            cycles(1);
        end
        cycles(2);
    endtask : zc_until

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] d;
        host.rd(8'h02, d); chk("batcfg rst", 8'h04, d);
        host.rd(8'h07, d); chk("l3cfg rst", 8'h01, d);
        host.rd(8'h08, d); chk("l2cfg rst", 8'h01, d);
        host.rd(8'h09, d); chk("l1cfg rst", 8'h01, d);
        host.rd(8'h03, d); chk("bstv rst", 8'h00, d);
        host.rd(8'h04, d); chk("bsti rst", 8'h00, d);
        host.wr(8'h05, 8'h5A);
        host.rd(8'h05, d); chk("unmapped", 8'h00, d);
        host.wr(8'h03, 8'hFD);
        host.wr(8'h04, 8'h3E);
        host.rd(8'h03, d); chk("bstv rd", 8'hFD, d);
        chk("vsel", 8'h05, {5'h00, vsel});
        chk("ilim", 8'h06, {5'h00, ilim});
    endtask : t_regs

    task automatic t_attack3();
        do_reset(2);
        peak = 14'd5800;
        zc_until(5'h1F, 20);
        chk("no attack atten", 8'h00, {3'h0, atten});
        chk("no attack level", 8'h00, {6'h00, lvl});
        host.wr(`MAGC_OFS_L3CFG, 8'h05);
        peak = 14'd6500;
        cycles(24);
        zc = 1'b1;
        cycles(1);
        zc = 1'b0;
        cycles(2);
        chk("slow rate", 8'h00, {3'h0, atten});
        cycles(40);
        chk("no zc atten", 8'h00, {3'h0, atten});
        chk("level3", 8'h03, {6'h00, lvl});
        zc = 1'b1;
        cycles(1);
        zc = 1'b0;
        cycles(2);
        chk("one step", 8'h01, {3'h0, atten});
    endtask : t_attack3

    task automatic t_levels();
        logic [7:0] d;
        do_reset(2);
        peak = 14'd8500;
        clip = 1'b1;
        cycles(3);
        chk("level1", 8'h01, {6'h00, lvl});
        clip = 1'b0;
        cycles(3);
        chk("level2", 8'h02, {6'h00, lvl});
        host.wr(8'h08, 8'h00);
        cycles(3);
        chk("level2 off", 8'h03, {6'h00, lvl});
        clip = 1'b1;
        zc_until(5'h1B, 200);
        zc_until(5'h1C, 20);
        chk("max atten", 8'h1B, {3'h0, atten});
        host.wr(`MAGC_OFS_STATUS, 8'hFF);
        host.rd(`MAGC_OFS_STATUS, d);
        chk("status", 8'h3B, d);
    endtask : t_levels

    task automatic t_release();
        peak = 14'd5000;
        clip = 1'b0;
        cycles(2);
        zc_until(5'h00, 14);
        chk("hold atten", 8'h1B, {3'h0, atten});
        zc_until(5'h18, 200);
        chk("release step", 8'h18, {3'h0, atten});
        peak = 14'd5800;
        zc_until(5'h00, 30);
        chk("release stop", 8'h18, {3'h0, atten});
        peak = 14'd5000;
        zc_until(5'h00, 900);
        zc_until(5'h1F, 20);
        chk("initial gain", 8'h00, {3'h0, atten});
    endtask : t_release

    task automatic t_battery();
        do_reset(2);
        peak = 14'd5200;
        bat = 13'd3400;
        cycles(3);
        chk("bat prot", 8'h01, {7'h00, prot});
        chk("bat level", 8'h01, {6'h00, lvl});
        bat = 13'd3599;
        cycles(3);
        chk("hysteresis", 8'h01, {7'h00, prot});
        bat = 13'd3600;
        cycles(3);
        chk("bat clear", 8'h00, {7'h00, prot});
        host.wr(8'h02, 8'h1C);
        bat = 13'd3580;
        cycles(3);
        chk("bat th3", 8'h01, {7'h00, prot});
        host.wr(8'h02, 8'h1F);
        bat = 13'd3400;
        peak = 14'd5900;
        cycles(3);
        chk("bat lim3", 8'h00, {6'h00, lvl});
        host.wr(8'h02, 8'h18);
        cycles(3);
        chk("bat off", 8'h00, {7'h00, prot});
    endtask : t_battery

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        cycles(20);
        rst = 1'b0;
        t_regs();
        t_attack3();
        t_levels();
        t_release();
        t_battery();
        wrap_up();
    end
endmodule : magc_gain_ctrl_tb

`default_nettype wire
